// >>> include/psw_pkg.sv
// Overview of operation
// - Four switching inputs, one axis each
// - Rising input edge zeroes its axis
// - Mill: 10 outputs, 5 with spindle
// - Turn: 10 outputs, 5 with surface speed
// - Coupled or backlash axes never switch
// - Per-output axis and relation code
// - Compare actual or distance-to-go value
// - Point type or range about zero
// - Polarity picks relay on or off
// - Pulse holds active state for period
// - Period 0.1 s to 999.9 s
// - Timer starts on condition rising
// - New rising restarts full period
// - Clear command erases output settings
// - Spindle needs mill, rotary, speed, enable
package psw_pkg;
   localparam int NAXES        = 4;
   localparam int NOUT         = 10;
   localparam int NOUT_REDUCED = 5;
   localparam int POS_W        = 32;
   localparam int CLK_HZ       = 25000000;
   localparam int STEP_MS      = 100;
   localparam int STEP_CYC     = CLK_HZ / 1000 * STEP_MS;
   localparam int PER_W        = 14;
   localparam int TMR_W        = 36;
   localparam logic [PER_W-1:0] PER_MIN = 14'h0001;
   localparam logic [PER_W-1:0] PER_MAX = 14'h270F;
   // Register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_AXIS   = 8'h08;
   localparam logic [7:0] REG_CLEAR  = 8'h0C;
   localparam logic [7:0] REG_OUT    = 8'h40;
   localparam logic [7:0] REG_OUT_END = 8'h90;
   // Control and status bits
   localparam int CTRL_W     = 5;
   localparam int CTRL_TURN  = 0;
   localparam int CTRL_SPN   = 1;
   localparam int CTRL_ROT   = 2;
   localparam int CTRL_SPD   = 3;
   localparam int CTRL_CSS   = 4;
   localparam int ST_SPIN    = 16;
   localparam int ST_CNT_LSB = 24;
   // Output configuration word
   localparam int CFG_W     = 24;
   localparam int CFG_AXIS  = 0;
   localparam int CFG_REL   = 2;
   localparam int CFG_REF   = 5;
   localparam int CFG_RANGE = 6;
   localparam int CFG_INV   = 7;
   localparam int CFG_PULSE = 8;
   localparam int CFG_PER   = 10;
   typedef enum logic [2:0] {
      REL_OFF = 3'h0, REL_LT = 3'h1, REL_LE = 3'h2, REL_GE = 3'h3, REL_GT = 3'h4
   } psw_rel_t;
endpackage

// >>> src/psw_top.sv
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module psw_top #(
   parameter int PULSE_STEP_CYC = psw_pkg::STEP_CYC
) (
   // Clock, reset, enable
   input  wire logic                                          clk_i,
   input  wire logic                                          rst_i,
   input  wire logic                                          ce_i,
   // Wishbone slave
   input  wire logic                                          cyc_i,
   input  wire logic                                          stb_i,
   input  wire logic                                          we_i,
   input  wire logic [7:0]                                    adr_i,
   input  wire logic [3:0]                                    sel_i,
   input  wire logic [31:0]                                   dat_i,
   output logic      [31:0]                                   dat_o,
   output logic                                               ack_o,
   // Axis positions
   input  wire logic [psw_pkg::NAXES*psw_pkg::POS_W-1:0]      act_pos_i,
   input  wire logic [psw_pkg::NAXES*psw_pkg::POS_W-1:0]      dtg_pos_i,
   // Switching inputs and outputs
   input  wire logic [psw_pkg::NAXES-1:0]                     switch_in_i,
   output logic      [psw_pkg::NAXES-1:0]                     zero_axis_o,
   output logic      [psw_pkg::NOUT-1:0]                      relay_o
);
   import psw_pkg::*;

   typedef struct packed {
      logic                              ack;
      logic [31:0]                       dat;
      logic [CTRL_W-1:0]                 ctrl;
      logic [NAXES-1:0]                  coupled;
      logic [NAXES-1:0]                  backlash;
      logic [NOUT-1:0][CFG_W-1:0]        cfg;
      logic [NOUT-1:0][POS_W-1:0]        pt;
      logic [NOUT-1:0][TMR_W-1:0]        tmr;
      logic [NOUT-1:0]                   cond_q;
      logic [NOUT-1:0]                   relay;
      logic [NAXES-1:0]                  sw_q;
      logic [NAXES-1:0]                  zero;
   } psw_state_t;

   psw_state_t                    r;
   psw_state_t                    next_r;
   logic                          spin_on;
   logic                          reduced;
   logic                          bus_req;
   logic [NOUT-1:0]               cond;
   logic [NOUT-1:0][TMR_W-1:0]    per_cyc;
   logic [NOUT-1:0][POS_W-1:0]    val;
   logic [3:0]                    oidx;
   logic                          ohit;
   logic                          opt;
   logic [31:0]                   wmask;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic rel_hit(input logic [2:0] rel,
                                    input logic signed [POS_W-1:0] a,
                                    input logic signed [POS_W-1:0] b);
      case (rel)
         REL_LT:  rel_hit = a < b;
         REL_LE:  rel_hit = a <= b;
         REL_GE:  rel_hit = a >= b;
         REL_GT:  rel_hit = a > b;
         default: rel_hit = 1'b0;
      endcase
   endfunction

   // Output slot decode, shared by read and write paths
   function automatic logic [5:0] out_dec(input logic [7:0] adr);
      logic [7:0] off;
      off = adr - REG_OUT;
      out_dec = {adr >= REG_OUT && adr < REG_OUT_END, off[2], off[6:3]};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [31:0] m);
      merge = (old & ~m) | (d & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_r = r;
      spin_on = 1'b0;
      reduced = 1'b0;
      bus_req = 1'b0;
      cond = '0;
      per_cyc = '0;
      val = '0;
      wmask = '0;
      {ohit, opt, oidx} = out_dec(adr_i);
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{sel_i[b]}};
      end

      // Only the rising edge counts; level and falling edge do nothing
      next_r.sw_q = switch_in_i;
      next_r.zero = switch_in_i & ~r.sw_q;

      spin_on = !r.ctrl[CTRL_TURN] && r.ctrl[CTRL_ROT]
                && r.ctrl[CTRL_SPD] && r.ctrl[CTRL_SPN];
      // Speed control owns half the relays in either application
      reduced = r.ctrl[CTRL_TURN] ? r.ctrl[CTRL_CSS] : spin_on;

      for (int i = 0; i < NOUT; i++) begin
         logic [1:0]       ax;
         logic [2:0]       rel;
         logic [PER_W-1:0] per;
         ax = r.cfg[i][CFG_AXIS +: 2];
         rel = r.cfg[i][CFG_REL +: 3];
         per = r.cfg[i][CFG_PER +: PER_W];
         val[i] = r.cfg[i][CFG_REF] ? dtg_pos_i[ax*POS_W +: POS_W]
                                   : act_pos_i[ax*POS_W +: POS_W];
         // Range type measures distance from zero
         if (r.cfg[i][CFG_RANGE] && val[i][POS_W-1]) begin
            val[i] = POS_W'(0) - val[i];
         end
         cond[i] = rel_hit(rel, val[i], r.pt[i])
                   && !(reduced && i >= NOUT_REDUCED)
                   && !r.coupled[ax] && !r.backlash[ax];
         if (per < PER_MIN) begin
            per = PER_MIN;
         end else if (per > PER_MAX) begin
            per = PER_MAX;
         end
         per_cyc[i] = TMR_W'(per) * TMR_W'(PULSE_STEP_CYC);
         next_r.cond_q[i] = cond[i];
         if (rel == REL_OFF || !r.cfg[i][CFG_PULSE]) begin
            next_r.tmr[i] = '0;
         end else if (cond[i] && !r.cond_q[i]) begin
            next_r.tmr[i] = per_cyc[i];
         end else if (r.tmr[i] != '0) begin
            next_r.tmr[i] = r.tmr[i] - TMR_W'(1);
         end
         if (r.cfg[i][CFG_PULSE]) begin
            next_r.relay[i] = (next_r.tmr[i] != '0) ^ r.cfg[i][CFG_INV];
         end else begin
            next_r.relay[i] = cond[i] ^ r.cfg[i][CFG_INV];
         end
      end

      // Bus: answer one cycle after request, then drop for a cycle
      next_r.ack = 1'b0;
      bus_req = cyc_i && stb_i && !r.ack;
      if (bus_req) begin
         next_r.ack = 1'b1;
         next_r.dat = '0;
         if (adr_i == REG_CTRL) begin
            next_r.dat[CTRL_W-1:0] = r.ctrl;
         end else if (adr_i == REG_STATUS) begin
            next_r.dat[NOUT-1:0] = r.relay;
            next_r.dat[ST_SPIN] = spin_on;
            next_r.dat[ST_CNT_LSB +: 4] = reduced ? 4'(NOUT_REDUCED) : 4'(NOUT);
         end else if (adr_i == REG_AXIS) begin
            next_r.dat[2*NAXES-1:0] = {r.backlash, r.coupled};
         end else if (ohit) begin
            next_r.dat = opt ? r.pt[oidx] : 32'(r.cfg[oidx]);
         end
         if (we_i) begin
            if (adr_i == REG_CTRL) begin
               next_r.ctrl = CTRL_W'(merge(32'(r.ctrl), dat_i, wmask));
            end else if (adr_i == REG_AXIS) begin
               {next_r.backlash, next_r.coupled} =
                  (2*NAXES)'(merge(32'({r.backlash, r.coupled}), dat_i, wmask));
            end else if (adr_i == REG_CLEAR) begin
               for (int i = 0; i < NOUT; i++) begin
                  if (dat_i[i] && sel_i[i/8]) begin
                     next_r.cfg[i] = '0;
                     next_r.pt[i] = '0;
                     next_r.tmr[i] = '0;
                  end
               end
            end else if (ohit && opt) begin
               next_r.pt[oidx] = merge(r.pt[oidx], dat_i, wmask);
            end else if (ohit) begin
               next_r.cfg[oidx] = CFG_W'(merge(32'(r.cfg[oidx]), dat_i, wmask));
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign dat_o = r.dat;
   assign ack_o = r.ack;
   assign zero_axis_o = r.zero;
   assign relay_o = r.relay;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_zero_edge: assert property (ce_i && switch_in_i[0] && !r.sw_q[0] |=> zero_axis_o[0])
      else $error("rising input did not zero its axis");
   a_zero_quiet: assert property (ce_i && !(|(switch_in_i & ~r.sw_q))
      |=> zero_axis_o == '0)
      else $error("zero request without rising input");
   a_reduced_outs: assert property (reduced |-> cond[NOUT-1:NOUT_REDUCED] == '0)
      else $error("upper output switched while reduced");
   a_locked_axis: assert property ((r.coupled | r.backlash) == 4'hF |-> cond == '0)
      else $error("output switched on a locked axis");
   a_off_idle: assert property (ce_i && r.cfg[0][CFG_REL +: 3] == REL_OFF
      |=> r.tmr[0] == '0 && relay_o[0] == $past(r.cfg[0][CFG_INV]))
      else $error("off output left its inactive state");
   a_pulse_start: assert property (ce_i && r.cfg[0][CFG_PULSE] && cond[0] && !r.cond_q[0]
      |=> r.tmr[0] == $past(per_cyc[0]) && relay_o[0] != r.cfg[0][CFG_INV])
      else $error("pulse timer not loaded on rising condition");
   a_cont_follow: assert property (ce_i && !r.cfg[0][CFG_PULSE]
      |=> relay_o[0] == ($past(cond[0]) ^ $past(r.cfg[0][CFG_INV])))
      else $error("continuous relay does not follow condition");
   a_pulse_end: assert property (ce_i && r.cfg[0][CFG_PULSE] && r.tmr[0] == TMR_W'(1)
      && !(cond[0] && !r.cond_q[0]) && !bus_req
      |=> r.tmr[0] == '0 && relay_o[0] == r.cfg[0][CFG_INV])
      else $error("pulse did not end at expiry");
   a_period_span: assert property (per_cyc[0] >= TMR_W'(PULSE_STEP_CYC)
      && per_cyc[0] <= TMR_W'(PER_MAX) * TMR_W'(PULSE_STEP_CYC))
      else $error("pulse period out of range");
   a_clear_cfg: assert property (ce_i && bus_req && we_i && adr_i == REG_CLEAR
      && dat_i[0] && sel_i[0] |=> r.cfg[0] == '0 && r.pt[0] == '0)
      else $error("clear left settings behind");
   a_spin_gate: assert property (spin_on |-> !r.ctrl[CTRL_TURN] && r.ctrl[CTRL_SPN])
      else $error("spindle active outside its conditions");
   a_wb_ack: assert property (ce_i && bus_req |=> ack_o ##1 !ack_o || !ce_i)
      else $error("bus answer not a single cycle");

   c_pulse_run: cover property (r.cfg[0][CFG_PULSE] && r.tmr[0] == TMR_W'(1));
   c_retrigger: cover property (r.tmr[0] != '0 && cond[0] && !r.cond_q[0]);
   c_zero_in: cover property (zero_axis_o[0]);
   c_reduced: cover property (reduced && spin_on);
endmodule

// >>> bench/psw_partner.sv
`timescale 1ns/1ps
// Switch contacts and relay coils beyond the block
module psw_partner (
   // Clock
   input  wire logic [0:0]              clk_i,
   // Relay drive from the block
   input  wire logic [psw_pkg::NOUT-1:0] relay_i,
   // Contacts towards the block
   output logic      [psw_pkg::NAXES-1:0] contact_o
);
   int on_cnt = 0;
   initial contact_o = 4'h0;
   // Contacts move just after an edge, never mid-cycle
   task automatic set_contact(input int n, input logic v);
      @(posedge clk_i);
      contact_o[n] <= v;
   endtask
   // On-time of relay 0 in cycles, for pulse length checks
   always @(posedge clk_i) begin
      if (relay_i[0] === 1'b1) begin
         on_cnt <= on_cnt + 1;
      end
   end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import psw_pkg::*;
   logic                   clk_i = 1'b0;
   logic                   rst_i = 1'b1;
   logic                   ce = 1'b1;
   logic                   cyc = 1'b0;
   logic                   stb = 1'b0;
   logic                   we = 1'b0;
   logic [7:0]             adr = 8'h00;
   logic [31:0]            wdat = 32'h0;
   logic [31:0]            rdat;
   logic [31:0]            dat_o;
   logic                   ack_o;
   logic [NAXES*POS_W-1:0] act = '0;
   logic [NAXES*POS_W-1:0] dtg = '0;
   logic [NAXES-1:0]       sw;
   logic [NAXES-1:0]       zero;
   logic [NOUT-1:0]        relay;
   int                     error_cnt = 0;
   int                     checked = 0;
   int                     n0;
   always #20 clk_i = ~clk_i;
   psw_top #(.PULSE_STEP_CYC(4)) i_psw_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
      .dat_o(dat_o), .ack_o(ack_o), .act_pos_i(act), .dtg_pos_i(dtg),
      .switch_in_i(sw), .zero_axis_o(zero), .relay_o(relay));
   psw_partner i_psw_partner (.clk_i(clk_i), .relay_i(relay), .contact_o(sw));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Holds the request until ack is sampled; the next call leaves one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   function automatic logic [31:0] cf(input logic [2:0] r, input logic i, p, g, f,
                                      input logic [13:0] t);
      return {8'h00, t, 1'b0, p, i, g, f, r, 2'b00};
   endfunction
   task automatic setout(input int i, input logic [31:0] c, input logic [31:0] pt);
      wb(1'b1, REG_OUT + 8'(8 * i), c);
      wb(1'b1, REG_OUT + 8'(8 * i + 4), pt);
      tick(3);
   endtask
   task automatic pos(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      act[31:0] <= a;
      dtg[31:0] <= d;
      tick(3);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_switch();
      for (int n = 0; n < NAXES; n++) begin
         i_psw_partner.set_contact(n, 1'b1);
         tick(1);
         chk("zero_rise", 32'(1 << n), 32'(zero));
         tick(1);
         chk("zero_after", 32'h0, 32'(zero));
         i_psw_partner.set_contact(n, 1'b0);
         tick(2);
         chk("zero_fall", 32'h0, 32'(zero));
      end
      $display("switch test done");
   endtask
   // Enable low must hold the edge detector; the edge shows once enabled
   task automatic t_freeze();
      @(posedge clk_i);
      ce <= 1'b0;
      i_psw_partner.set_contact(0, 1'b1);
      tick(2);
      chk("frozen", 32'h0, 32'(zero));
      @(posedge clk_i);
      ce <= 1'b1;
      tick(1);
      chk("thawed", 32'h1, 32'(zero));
      i_psw_partner.set_contact(0, 1'b0);
      tick(2);
      $display("freeze test done");
   endtask
   task automatic t_count();
      logic [4:0] ctl [4] = '{5'h0E, 5'h06, 5'h11, 5'h10};
      logic [3:0] cnt [4] = '{4'h5, 4'hA, 4'h5, 4'hA};
      wb(1'b0, REG_STATUS, 32'h0);
      chk("usable", 32'hA, 32'(rdat[27:24]));
      setout(7, cf(REL_GE, 0, 0, 0, 0, 0), 32'h0);
      chk("relay7", 32'h1, 32'(relay[7]));
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, REG_CTRL, 32'(ctl[k]));
         wb(1'b0, REG_STATUS, 32'h0);
         chk("usable", 32'(cnt[k]), 32'(rdat[27:24]));
         chk("spindle", 32'(k == 0), 32'(rdat[ST_SPIN]));
         tick(3);
         chk("relay7", 32'(cnt[k] == 4'hA), 32'(relay[7]));
      end
      wb(1'b1, REG_CTRL, 32'h0);
      wb(1'b1, REG_CLEAR, 32'h80);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rdat);
      $display("count test done");
   endtask
   task automatic t_relation();
      logic [4:0] at_eq = 5'b01100;
      logic [4:0] below = 5'b00110;
      for (int r = 0; r < 5; r++) begin
         setout(0, cf(3'(r), 0, 0, 0, 0, 0), 32'h64);
         pos(32'h64, 32'h0);
         chk("rel_eq", 32'(at_eq[r]), 32'(relay[0]));
         pos(32'h63, 32'h0);
         chk("rel_below", 32'(below[r]), 32'(relay[0]));
      end
      setout(0, cf(REL_GT, 1, 0, 0, 0, 0), 32'h64);
      chk("inv_unmet", 32'h1, 32'(relay[0]));
      pos(32'h65, 32'h0);
      chk("inv_met", 32'h0, 32'(relay[0]));
      $display("relation test done");
   endtask
   task automatic t_refs();
      pos(-32'sd20, 32'h0);
      setout(0, cf(REL_GE, 0, 0, 1, 0, 0), 32'hA);
      chk("range", 32'h1, 32'(relay[0]));
      setout(0, cf(REL_GE, 0, 0, 0, 0, 0), 32'hA);
      chk("point", 32'h0, 32'(relay[0]));
      setout(0, cf(REL_GT, 0, 0, 0, 1, 0), 32'h64);
      pos(-32'sd20, 32'hC8);
      chk("dtg", 32'h1, 32'(relay[0]));
      wb(1'b1, REG_AXIS, 32'h1);
      tick(3);
      chk("coupled", 32'h0, 32'(relay[0]));
      wb(1'b1, REG_AXIS, 32'h10);
      tick(3);
      chk("backlash", 32'h0, 32'(relay[0]));
      wb(1'b1, REG_AXIS, 32'h0);
      tick(3);
      chk("free_axis", 32'h1, 32'(relay[0]));
      wb(1'b1, REG_CLEAR, 32'h1);
      tick(3);
      chk("cleared", 32'h0, 32'(relay[0]));
      wb(1'b0, REG_OUT, 32'h0);
      chk("cfg_clr", 32'h0, rdat);
      $display("reference test done");
   endtask
   task automatic t_pulse();
      pos(-32'sd5, 32'h0);
      setout(0, cf(REL_GT, 0, 1, 0, 0, 14'h1), 32'h0);
      n0 = i_psw_partner.on_cnt;
      pos(32'h5, 32'h0);
      tick(20);
      chk("pulse_len", 32'h4, 32'(i_psw_partner.on_cnt - n0));
      chk("pulse_end", 32'h0, 32'(relay[0]));
      // Second rise 4 cycles after the first restarts a full 8-cycle period
      setout(0, cf(REL_GT, 0, 1, 0, 0, 14'h2), 32'h0);
      pos(-32'sd5, 32'h0);
      n0 = i_psw_partner.on_cnt;
      act[31:0] <= 32'h5;
      repeat (3) @(posedge clk_i);
      act[31:0] <= -32'sd5;
      @(posedge clk_i);
      act[31:0] <= 32'h5;
      tick(30);
      chk("restart", 32'hC, 32'(i_psw_partner.on_cnt - n0));
      $display("pulse test done");
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_switch();
      t_freeze();
      t_count();
      t_relation();
      t_refs();
      t_pulse();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      results();
   end
endmodule
